// ---- include/iqe_map.vh ----
// Operation
// R1: 160 positions per pole pair, 40 pulses
// R2: A and B quarter cycle apart, direction-ordered
// R3: index only with positive reference at rising crossing
// R4: index output active high, low elsewhere
// R5: one push-pull/open-drain select for A, B, index
// R6: default 40 pulses, index enabled
// R7: monitor output disabled until function chosen
// R8: monitor output can carry digital alarm
// R9: system holds retest input at ground
// R10: counter clears on index, then counts edges
// R11: interpolation factor 40,20,10,5,32,16,8,4 selectable
// R12: push-pull by default, open-drain once programmed
// R13: lock setting rejects further configuration changes
// R14: each position step toggles one output only
`ifndef IQE_MAP_VH
`define IQE_MAP_VH

`define IQE_POS_PER_PP       16'h00A0
`define IQE_POS_W            8

`define IQE_ADDR_W           4
`define IQE_REG_CFG          4'h0
`define IQE_REG_STATUS       4'h4
`define IQE_REG_MASK         4'h8
`define IQE_REG_POS          4'hC

`define IQE_CFG_FACTOR_LSB   0
`define IQE_CFG_FACTOR_MSB   2
`define IQE_CFG_OPEN_DRAIN   3
`define IQE_CFG_MON_LSB      4
`define IQE_CFG_MON_MSB      6
`define IQE_CFG_INDEX_EN     7
`define IQE_CFG_LOCK         8
`define IQE_CFG_THR_LSB      16
`define IQE_CFG_THR_MSB      27

`define IQE_FACTOR_RST       3'h0
`define IQE_MON_RST          3'h0
`define IQE_THR_RST          12'h100

`define IQE_MON_OFF          3'h0
`define IQE_MON_FIELD        3'h1
`define IQE_MON_SIN          3'h2
`define IQE_MON_COS          3'h3
`define IQE_MON_REF          3'h4
`define IQE_MON_ALARM        3'h5

`define IQE_ST_INDEX         0
`define IQE_ST_ALARM         1
`define IQE_ST_REJECT        2
`define IQE_ST_W             3

`define IQE_INDEX_NS         200
`define IQE_CLK_MHZ          250

`endif

// ---- core/iqe_sync.v ----
module iqe_sync (
	input  wire core_clk,
	input  wire rst_b,
	input  wire async_in,
	output wire sync_out
);
	reg meta_ff;
	reg sync_ff;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ---- core/iqe_quad_gen.v ----
`include "iqe_map.vh"

module iqe_quad_gen #(
	parameter POS_W = `IQE_POS_W
) (
	input  wire             core_clk,
	input  wire             rst_b,
	input  wire [POS_W-1:0] pos,
	input  wire [2:0]       factor_sel,
	output reg              quad_a,
	output reg              quad_b
);
	reg  [7:0]  edges_per_pp;
	wire [15:0] prod;
	wire [15:0] step;

	// quadrature edges per pole pair are four times the pulse count
	always @* begin
		case (factor_sel)
			3'h0: edges_per_pp = 8'hA0; // [R11] [R6]
			3'h1: edges_per_pp = 8'h50;
			3'h2: edges_per_pp = 8'h28;
			3'h3: edges_per_pp = 8'h14;
			3'h4: edges_per_pp = 8'h80;
			3'h5: edges_per_pp = 8'h40;
			3'h6: edges_per_pp = 8'h20;
			default: edges_per_pp = 8'h10;
		endcase
	end

	// at most one edge per position since edges never exceed positions
	assign prod = {{(16-POS_W){1'b0}}, pos} * {8'h00, edges_per_pp};
	assign step = prod / `IQE_POS_PER_PP; // [R1]

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			quad_a <= 1'b0;
			quad_b <= 1'b0;
		end else begin
			quad_a <= step[1] ^ step[0]; // [R2] [R14]
			quad_b <= step[1];           // [R14]
		end
	end
endmodule

// ---- core/iqe_encoder.v ----
// The placing of the registers and the plain strobed port were decided locally.
`include "iqe_map.vh"

module iqe_encoder #(
	parameter SIG_W = 12,
	parameter POS_W = `IQE_POS_W
) (
	input  wire                    core_clk,
	input  wire                    rst_b,
	input  wire [POS_W-1:0]        interp_pos,
	input  wire signed [SIG_W-1:0] in_phase_track_signal,
	input  wire signed [SIG_W-1:0] shifted_track_signal,
	input  wire signed [SIG_W-1:0] ref_track_signal,
	input  wire                    retest_input,
	input  wire [`IQE_ADDR_W-1:0]  reg_addr,
	input  wire [31:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [31:0]             reg_rdata,
	output wire                    irq,
	output reg                     quad_a_out,
	output reg                     quad_a_oe,
	output reg                     quad_b_out,
	output reg                     quad_b_oe,
	output reg                     index_out,
	output reg                     index_oe,
	output reg                     monitor_out,
	output reg                     monitor_oe,
	output wire [2:0]              monitor_sel
);
	// the product is worked out at full width, then cut to the counter's width on purpose
	localparam integer INDEX_CYC_FULL = (`IQE_INDEX_NS * `IQE_CLK_MHZ) / 1000;
	localparam [7:0]   INDEX_CYC      = INDEX_CYC_FULL[7:0];

	reg  [2:0]             factor_ff;
	reg                    open_drain_ff;
	reg  [2:0]             mon_sel_ff;
	reg                    index_en_ff;
	reg                    lock_ff;
	reg  [SIG_W-1:0]       thr_ff;
	reg  [`IQE_ST_W-1:0]   status_ff;
	reg  [`IQE_ST_W-1:0]   mask_ff;
	reg                    sin_neg_ff;
	reg  [7:0]             index_cnt_ff;
	reg                    alarm_ff;
	reg  [`IQE_ST_W-1:0]   nxt_status;
	reg  [31:0]            nxt_rdata;
	wire                   retest_sync;
	wire                   quad_a;
	wire                   quad_b;
	wire                   rising_cross;
	wire                   ref_positive;
	wire                   index_hit;
	wire                   index_level;
	wire [SIG_W-1:0]       abs_sin;
	wire [SIG_W-1:0]       abs_cos;
	wire                   alarm_now;
	wire                   cfg_wr;
	wire                   reject;

	iqe_sync u_retest_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.async_in (retest_input),
		.sync_out (retest_sync)
	);

	iqe_quad_gen #(
		.POS_W (POS_W)
	) u_quad_gen (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pos        (interp_pos),
		.factor_sel (factor_ff),
		.quad_a     (quad_a),
		.quad_b     (quad_b)
	);

	// configuration writes bounce once the lock bit has been set
	assign cfg_wr = reg_wr && (reg_addr == `IQE_REG_CFG) && !lock_ff; // [R13]
	assign reject = reg_wr && (reg_addr == `IQE_REG_CFG) && lock_ff;  // [R13]

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			factor_ff     <= `IQE_FACTOR_RST; // [R6]
			open_drain_ff <= 1'b0;            // [R12]
			mon_sel_ff    <= `IQE_MON_RST;    // [R7]
			index_en_ff   <= 1'b1;            // [R6]
			lock_ff       <= 1'b0;
			thr_ff        <= `IQE_THR_RST;
		end else if (cfg_wr) begin
			factor_ff     <= reg_wdata[`IQE_CFG_FACTOR_MSB:`IQE_CFG_FACTOR_LSB]; // [R11]
			open_drain_ff <= reg_wdata[`IQE_CFG_OPEN_DRAIN]; // [R5] [R12]
			mon_sel_ff    <= reg_wdata[`IQE_CFG_MON_MSB:`IQE_CFG_MON_LSB];
			index_en_ff   <= reg_wdata[`IQE_CFG_INDEX_EN];
			lock_ff       <= reg_wdata[`IQE_CFG_LOCK];
			thr_ff        <= reg_wdata[`IQE_CFG_THR_MSB:`IQE_CFG_THR_LSB];
		end
	end

	// index: sin crosses from negative to non-negative while reference is above zero
	assign rising_cross = sin_neg_ff && !in_phase_track_signal[SIG_W-1];
	assign ref_positive = !ref_track_signal[SIG_W-1] && (ref_track_signal != {SIG_W{1'b0}});
	assign index_hit    = rising_cross && ref_positive && index_en_ff; // [R3]
	assign index_level  = (index_cnt_ff != 8'h00);

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sin_neg_ff   <= 1'b0;
			index_cnt_ff <= 8'h00;
		end else begin
			sin_neg_ff <= in_phase_track_signal[SIG_W-1];
			if (index_hit) begin
				index_cnt_ff <= INDEX_CYC; // [R3]
			end else if (index_level) begin
				index_cnt_ff <= index_cnt_ff - 8'h01;
			end
		end
	end

	// alarm when both tracks sit below the amplitude threshold
	assign abs_sin   = in_phase_track_signal[SIG_W-1] ? -in_phase_track_signal
		: in_phase_track_signal;
	assign abs_cos   = shifted_track_signal[SIG_W-1] ? -shifted_track_signal
		: shifted_track_signal;
	assign alarm_now = (abs_sin < thr_ff) && (abs_cos < thr_ff);

	// pin drivers: open-drain only pulls low, so the enable carries the level
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			quad_a_out  <= 1'b0;
			quad_a_oe   <= 1'b0;
			quad_b_out  <= 1'b0;
			quad_b_oe   <= 1'b0;
			index_out   <= 1'b0;
			index_oe    <= 1'b0;
			monitor_out <= 1'b0;
			monitor_oe  <= 1'b0;
			alarm_ff    <= 1'b0;
		end else begin
			alarm_ff <= alarm_now;
			if (open_drain_ff) begin // [R5]
				quad_a_out <= 1'b0;
				quad_a_oe  <= !quad_a;
				quad_b_out <= 1'b0;
				quad_b_oe  <= !quad_b;
				index_out  <= 1'b0;
				index_oe   <= !index_level; // [R4]
			end else begin
				quad_a_out <= quad_a; // [R2]
				quad_a_oe  <= 1'b1;
				quad_b_out <= quad_b;
				quad_b_oe  <= 1'b1;
				index_out  <= index_level; // [R4]
				index_oe   <= 1'b1;
			end
			// analog selections leave this digital driver off
			monitor_out <= (mon_sel_ff == `IQE_MON_ALARM) && alarm_now; // [R8]
			monitor_oe  <= (mon_sel_ff == `IQE_MON_ALARM);              // [R7] [R8]
		end
	end

	assign monitor_sel = mon_sel_ff; // [R7]

	// sticky status: a new event wins over a same-cycle clear
	always @* begin
		nxt_status = status_ff;
		if (reg_wr && (reg_addr == `IQE_REG_STATUS)) begin
			nxt_status = status_ff & ~reg_wdata[`IQE_ST_W-1:0];
		end
		if (index_hit) begin
			nxt_status[`IQE_ST_INDEX] = 1'b1;
		end
		if (alarm_now && !alarm_ff) begin
			nxt_status[`IQE_ST_ALARM] = 1'b1;
		end
		if (reject) begin
			nxt_status[`IQE_ST_REJECT] = 1'b1;
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_ff <= {`IQE_ST_W{1'b0}};
			mask_ff   <= {`IQE_ST_W{1'b0}};
		end else begin
			status_ff <= nxt_status;
			if (reg_wr && (reg_addr == `IQE_REG_MASK)) begin
				mask_ff <= reg_wdata[`IQE_ST_W-1:0];
			end
		end
	end

	assign irq = |(status_ff & mask_ff);

	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (reg_addr == `IQE_REG_CFG) begin
			nxt_rdata[`IQE_CFG_FACTOR_MSB:`IQE_CFG_FACTOR_LSB] = factor_ff;
			nxt_rdata[`IQE_CFG_OPEN_DRAIN]                     = open_drain_ff;
			nxt_rdata[`IQE_CFG_MON_MSB:`IQE_CFG_MON_LSB]       = mon_sel_ff;
			nxt_rdata[`IQE_CFG_INDEX_EN]                       = index_en_ff;
			nxt_rdata[`IQE_CFG_LOCK]                           = lock_ff;
			nxt_rdata[`IQE_CFG_THR_MSB:`IQE_CFG_THR_LSB]       = thr_ff;
		end else if (reg_addr == `IQE_REG_STATUS) begin
			nxt_rdata[`IQE_ST_W-1:0] = status_ff;
		end else if (reg_addr == `IQE_REG_MASK) begin
			nxt_rdata[`IQE_ST_W-1:0] = mask_ff;
		end else if (reg_addr == `IQE_REG_POS) begin
			nxt_rdata[POS_W-1:0] = interp_pos;
			nxt_rdata[8]         = quad_a;
			nxt_rdata[9]         = quad_b;
			nxt_rdata[10]        = index_level;
			nxt_rdata[11]        = alarm_ff;
			// a high level here means the retest pin is not tied low
			nxt_rdata[12]        = retest_sync; // [R9]
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= nxt_rdata;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// ---- tb/iqe_encoder_properties.sv ----
module iqe_encoder_properties #(
	parameter SIG_W = 12,
	parameter POS_W = 8
) (
	input wire                    core_clk,
	input wire                    rst_b,
	input wire [POS_W-1:0]        interp_pos,
	input wire signed [SIG_W-1:0] in_phase_track_signal,
	input wire signed [SIG_W-1:0] shifted_track_signal,
	input wire signed [SIG_W-1:0] ref_track_signal,
	input wire                    quad_a_out,
	input wire                    quad_a_oe,
	input wire                    quad_b_out,
	input wire                    quad_b_oe,
	input wire                    index_out,
	input wire                    index_oe,
	input wire                    monitor_out,
	input wire                    monitor_oe,
	input wire [2:0]              monitor_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	wire signed [SIG_W-1:0] s = in_phase_track_signal;
	wire signed [SIG_W-1:0] c = shifted_track_signal;
	wire signed [SIG_W-1:0] r = ref_track_signal;
	// pin levels with pull-ups, so both drive modes read alike
	wire ap = quad_a_oe ? quad_a_out : 1'b1;
	wire bp = quad_b_oe ? quad_b_out : 1'b1;
	wire ip = index_oe ? index_out : 1'b1;
	wire al = (s < 0 ? -s : s) < 12'sh100 && (c < 0 ? -c : c) < 12'sh100;
	reg       neg_ff;
	reg [1:0] up_ff;
	reg [5:0] cnt_ff;
	wire up = up_ff == 2'h3;
	wire hit = neg_ff & ~s[SIG_W-1] & ~r[SIG_W-1] & |r;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			neg_ff <= 1'b0;
			up_ff <= 2'h0;
			cnt_ff <= 6'h3F;
		end else begin
			neg_ff <= s[SIG_W-1];
			up_ff <= up ? up_ff : up_ff + 2'h1;
			cnt_ff <= hit ? 6'h0 : cnt_ff + {5'h0, cnt_ff != 6'h3F};
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_index_hit: assert property (hit |-> ##[2:3] ip)
		else $error("index missing after reference hit");
	chk_index_only: assert property ($rose(ip) |-> $past(hit, 2) || $past(hit, 3))
		else $error("index without reference hit");
	chk_index_width: assert property (up && ip |-> cnt_ff inside {[6'h1:6'h34]})
		else $error("index high outside its pulse");
	chk_one_edge: assert property (up |-> !($changed(ap) && $changed(bp)))
		else $error("both quadrature outputs moved together");
	chk_cw_order: assert property (up && $changed({ap, bp}) &&
		$past(interp_pos, 2) > $past(interp_pos, 3) |-> {ap, bp} == {~$past(bp), $past(ap)})
		else $error("forward order wrong");
	chk_ccw_order: assert property (up && $changed({ap, bp}) &&
		$past(interp_pos, 2) < $past(interp_pos, 3) |-> {ap, bp} == {$past(bp), ~$past(ap)})
		else $error("reverse order wrong");
	chk_monitor_off: assert property (monitor_sel != 3'h5 && $past(monitor_sel) != 3'h5
		|-> !monitor_oe && !monitor_out)
		else $error("monitor driven while unselected");
	chk_alarm_route: assert property (monitor_oe && $past(monitor_oe) && $stable(al) &&
		al == $past(al, 2) |-> monitor_out == al)
		else $error("monitor does not carry alarm");
	chk_drive_mode: assert property (up && (quad_a_out || quad_b_out || index_out)
		|-> quad_a_oe && quad_b_oe && index_oe)
		else $error("outputs not in one drive mode");
	cov_index: cover property (hit ##2 ip);
	cov_alarm: cover property (monitor_oe && monitor_out);
	cov_open: cover property (up && !quad_a_oe);
endmodule

bind iqe_encoder iqe_encoder_properties #(.SIG_W(SIG_W), .POS_W(POS_W)) u_props (.*);

// ---- tb/iqe_counter_model.sv ----
module iqe_counter_model (
	input  wire                core_clk,
	input  wire                a,
	input  wire                b,
	input  wire                z,
	output logic signed [15:0] cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ab_ff = 2'h0;
	initial cnt = 16'sh0;
	always @(posedge core_clk) begin
		ab_ff <= {a, b};
		if (z)
			cnt <= 16'sh0;
		else if ({a, b} == {~ab_ff[0], ab_ff[1]})
			cnt <= cnt + 16'sh1;
		else if ({a, b} == {ab_ff[0], ~ab_ff[1]})
			cnt <= cnt - 16'sh1;
	end
endmodule

// ---- tb/iqe_encoder_tb_top.sv ----
module iqe_encoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic               core_clk = 1'b0;
	logic               rst_b = 1'b0;
	logic [7:0]         pos = 8'h0;
	logic signed [11:0] sn = 12'sh64;
	logic signed [11:0] cs = 12'sh0;
	logic signed [11:0] rf = 12'sh0;
	logic [3:0]         addr = 4'h0;
	logic [31:0]        wdata = 32'h0;
	logic [31:0]        rdata;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	wire [31:0]         reg_rdata;
	wire                irq, qa, qao, qb, qbo, ix, ixo, mo, moe;
	wire [2:0]          msel;
	wire signed [15:0]  cnt;
	wire                ap = qao ? qa : 1'b1;
	wire                bp = qbo ? qb : 1'b1;
	wire                ip = ixo ? ix : 1'b1;
	int                 n_errors = 0;
	int                 comparisons = 0;
	always #2 core_clk = ~core_clk;
	iqe_encoder DUT (.core_clk(core_clk), .rst_b(rst_b), .interp_pos(pos),
		.in_phase_track_signal(sn), .shifted_track_signal(cs), .ref_track_signal(rf),
		.retest_input(1'b0), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(reg_rdata), .irq(irq), .quad_a_out(qa), .quad_a_oe(qao),
		.quad_b_out(qb), .quad_b_oe(qbo), .index_out(ix), .index_oe(ixo),
		.monitor_out(mo), .monitor_oe(moe), .monitor_sel(msel));
	iqe_counter_model u_cnt (.core_clk(core_clk), .a(ap), .b(bp), .z(ip), .cnt(cnt));
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(logic [3:0] a, logic [31:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [3:0] a);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		rdata = reg_rdata;
	endtask
	// one position step per clock, never wrapping past 159
	task automatic go(int to);
		int p;
		p = pos;
		while (p != to) begin
			p += (to > p) ? 1 : -1;
			@(posedge core_clk);
			pos <= p[7:0];
		end
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic crossing(logic signed [11:0] r);
		@(posedge core_clk);
		rf <= r;
		sn <= -12'sh64;
		@(posedge core_clk);
		sn <= 12'sh64;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task automatic t_factor();
		int ppr[8] = '{40, 20, 10, 5, 32, 16, 8, 4};
		for (int k = 0; k < 8; k++) begin
			wr_reg(4'h0, 32'h0100_0080 | k);
			go(159);
			chk("edges up", 159 * 4 * ppr[k] / 160, cnt);
			go(0);
			chk("edges down", 32'h0, cnt);
		end
		wr_reg(4'h0, 32'h0100_0080);
		$display("factor test done");
	endtask
	task automatic t_index();
		go(4);
		crossing(-12'sh64);
		chk("index on negative ref", 1'h0, ip);
		chk("count kept", 32'h4, cnt);
		crossing(12'sh64);
		chk("index level", 1'h1, ip);
		wr_reg(4'h8, 32'h1);
		#1;
		chk("irq unmasked", 1'h1, irq);
		wr_reg(4'h4, 32'h7);
		#1;
		chk("irq cleared", 1'h0, irq);
		repeat (60) @(posedge core_clk);
		chk("index ended", 1'h0, ip);
		chk("count cleared", 32'h0, cnt);
		go(0);
		$display("index test done");
	endtask
	task automatic t_mon();
		for (int m = 1; m < 6; m++) begin
			wr_reg(4'h0, 32'h0100_0080 | (m << 4));
			repeat (3) @(posedge core_clk);
			chk("monitor select", m, msel);
			chk("monitor enable", m == 5, moe);
		end
		chk("alarm shown", 1'h1, mo);
		@(posedge core_clk);
		sn <= 12'sh3E8;
		repeat (4) @(posedge core_clk);
		#1;
		chk("alarm gone", 1'h0, mo);
		@(posedge core_clk);
		sn <= 12'sh64;
		wr_reg(4'h0, 32'h0100_0080);
		rd_reg(4'h4);
		chk("alarm event", 32'h2, rdata & 32'h2);
		$display("monitor test done");
	endtask
	task automatic t_od_lock();
		wr_reg(4'h0, 32'h0100_0088);
		go(1);
		chk("a drive", 1'h0, qao);
		chk("a out", 1'h0, qa);
		chk("b drive", 1'h1, qbo);
		chk("index drive", 1'h1, ixo);
		go(0);
		rd_reg(4'hC);
		chk("position reg", 32'h0800, rdata);
		wr_reg(4'h0, 32'h0100_0180);
		wr_reg(4'h0, 32'h0100_0181);
		rd_reg(4'h0);
		chk("locked cfg", 32'h0100_0180, rdata);
		rd_reg(4'h4);
		chk("reject flag", 32'h4, rdata & 32'h4);
		rd_reg(4'h2);
		chk("unmapped read", 32'h0, rdata);
		$display("drive and lock test done");
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		rd_reg(4'h0);
		chk("cfg reset", 32'h0100_0080, rdata);
		chk("monitor reset", 1'h0, moe);
		t_factor();
		t_index();
		t_mon();
		t_od_lock();
		complete_run();
	end
	initial begin
		#200000;
		n_errors++;
		$display("watchdog expired");
		complete_run();
	end
endmodule
